// ==== src/pfm_top.sv ====
/*
 * Two power factor supervision elements driving auxiliary relays 3 to 7,
 * with an APB register file and a masked level interrupt.
 * Assumes measurements arrive synchronous to pclk with a one-cycle valid.
 */
`timescale 1ns/1ps
module pfm_top #(
    parameter int unsigned TICK_CYCLES = pfm_pkg::PFM_TICK_CYCLES
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  meas_valid,
    input  wire pfm_pkg::pfm_meas_type meas,
    output logic      [4:0]            relay_out,
    output logic                       alarm_out,
    output logic                       irq
);

    // Reset image of all state, built once as a constant.
    function automatic pfm_pkg::pfm_regs_type pfm_reset();
        pfm_pkg::pfm_regs_type v;
        v = '0;
        for (int e = 0; e < 2; e++) begin
            v.cfg[e].func    = pfm_pkg::pfm_func_type'(pfm_pkg::PFM_RST_FUNC);
            v.cfg[e].relays  = pfm_pkg::PFM_RST_RELAYS;
            v.cfg[e].pickup  = pfm_pkg::PFM_RST_PICKUP;
            v.cfg[e].dropout = pfm_pkg::PFM_RST_DROPOUT;
            v.cfg[e].delay   = pfm_pkg::PFM_RST_DELAY;
            v.el[e].state    = pfm_pkg::PFM_IDLE;
        end
        v.vnom = pfm_pkg::PFM_RST_VNOM;
        return v;
    endfunction : pfm_reset

    // Level writes outside the legal range saturate to the nearest end.
    function automatic logic [7:0] pfm_clamp_pf(input logic [7:0] x);
        logic [7:0] y;
        y = x;
        if ($signed(x) > $signed(pfm_pkg::PFM_PF_MAX)) begin
            y = pfm_pkg::PFM_PF_MAX;
        end else if ($signed(x) < $signed(pfm_pkg::PFM_PF_MIN)) begin
            y = pfm_pkg::PFM_PF_MIN;
        end
        return y;
    endfunction : pfm_clamp_pf

    localparam pfm_pkg::pfm_regs_type RST_VAL  = pfm_reset();
    localparam logic [24:0]           TICK_END = 25'(TICK_CYCLES - 1);

    pfm_pkg::pfm_regs_type r_q;
    pfm_pkg::pfm_regs_type r_d;

    always_comb begin
        logic        rd_acc;
        logic        wr_acc;
        logic [31:0] rdata;
        logic        hit;
        logic        vall;
        logic [39:0] shifted;
        logic [6:0]  qn;
        logic [7:0]  qpf;
        logic [3:0]  irq_set;
        logic [3:0]  irq_clr;
        logic        latch_clr;
        logic        pick;
        logic        drop;
        logic        active;
        logic        run;
        logic [11:0] base;
        rd_acc    = 1'b0;
        wr_acc    = 1'b0;
        rdata     = 32'h00000000;
        hit       = 1'b0;
        vall      = 1'b1;
        shifted   = 40'h0000000000;
        qn        = 7'h00;
        qpf       = 8'h00;
        irq_set   = 4'h0;
        irq_clr   = 4'h0;
        latch_clr = 1'b0;
        pick      = 1'b0;
        drop      = 1'b0;
        active    = 1'b0;
        run       = 1'b0;
        base      = 12'h000;
        r_d       = r_q;

        // One-second timebase enable.
        r_d.tick = 1'b0;
        if (r_q.sec_cnt == TICK_END) begin
            r_d.sec_cnt = 25'h0000000;
            r_d.tick    = 1'b1;
        end else begin
            r_d.sec_cnt = r_q.sec_cnt + 25'h0000001;
        end

        // Sequential divide of real power times one hundred by apparent power.
        if (meas_valid) begin
            r_d.busy     = 1'b1;
            r_d.step     = pfm_pkg::PFM_DIV_TOP;
            r_d.rem      = {8'h00, meas.p} * pfm_pkg::PFM_PF_SCALE;
            r_d.den      = meas.s;
            r_d.quo      = 7'h00;
            r_d.div_lead = meas.lead;
            // Cross-multiplied threshold test, so no second divider is needed.
            for (int k = 0; k < 3; k++) begin
                if (({4'h0, meas.v[k]} * pfm_pkg::PFM_VTH_DEN)
                    <= ({4'h0, r_q.vnom} * pfm_pkg::PFM_VTH_NUM)) begin
                    vall = 1'b0;
                end
            end
            r_d.div_v_ok = vall;
            r_d.div_i_ok = |meas.i_present;
        end else if (r_q.busy) begin
            shifted = {8'h00, r_q.den} << r_q.step;
            qn      = r_q.quo;
            if (r_q.rem >= shifted) begin
                r_d.rem     = r_q.rem - shifted;
                qn[r_q.step] = 1'b1;
            end
            r_d.quo  = qn;
            r_d.step = r_q.step - 3'h1;
            if (r_q.step == 3'h0) begin
                r_d.busy = 1'b0;
                qpf      = {1'b0, qn};
                if (r_q.den == 32'h00000000 || qpf > pfm_pkg::PFM_PF_MAX) begin
                    qpf = pfm_pkg::PFM_PF_MAX;
                end
                if (r_q.div_lead && qpf != pfm_pkg::PFM_PF_MAX) begin
                    qpf = 8'h00 - qpf;
                end
                r_d.pf       = qpf;
                r_d.pf_valid = 1'b1;
                r_d.v_ok     = r_q.div_v_ok;
                r_d.i_ok     = r_q.div_i_ok;
            end
        end

        // APB slave: one wait state, write and read data at the ready edge.
        rd_acc    = psel && penable && !r_q.pready;
        wr_acc    = psel && penable && r_q.pready && pwrite;
        r_d.pready = rd_acc;
        if (rd_acc) begin
            for (int e = 0; e < 2; e++) begin
                base = pfm_pkg::PFM_EL_STRIDE * 12'(e);
                if (paddr == base + pfm_pkg::PFM_OFF_CFG) begin
                    hit   = 1'b1;
                    rdata = {25'h0000000, r_q.cfg[e].relays, r_q.cfg[e].func};
                end
                if (paddr == base + pfm_pkg::PFM_OFF_PICKUP) begin
                    hit   = 1'b1;
                    rdata = {{24{r_q.cfg[e].pickup[7]}}, r_q.cfg[e].pickup};
                end
                if (paddr == base + pfm_pkg::PFM_OFF_DROPOUT) begin
                    hit   = 1'b1;
                    rdata = {{24{r_q.cfg[e].dropout[7]}}, r_q.cfg[e].dropout};
                end
                if (paddr == base + pfm_pkg::PFM_OFF_DELAY) begin
                    hit   = 1'b1;
                    rdata = {16'h0000, r_q.cfg[e].delay};
                end
            end
            unique case (paddr)
                pfm_pkg::PFM_OFF_VNOM: begin
                    hit   = 1'b1;
                    rdata = {16'h0000, r_q.vnom};
                end
                pfm_pkg::PFM_OFF_STATUS: begin
                    hit   = 1'b1;
                    rdata = {15'h0000, r_q.el[1].latch, r_q.el[0].latch, r_q.el[1].state,
                             r_q.el[0].state, r_q.i_ok, r_q.v_ok, r_q.pf_valid, r_q.pf};
                end
                pfm_pkg::PFM_OFF_IRQSTAT: begin
                    hit   = 1'b1;
                    rdata = {28'h0000000, r_q.irq_stat};
                end
                pfm_pkg::PFM_OFF_IRQMASK: begin
                    hit   = 1'b1;
                    rdata = {28'h0000000, r_q.irq_mask};
                end
                pfm_pkg::PFM_OFF_CMD: begin
                    hit = 1'b1;
                end
                default: begin
                end
            endcase
            r_d.prdata  = hit ? rdata : 32'h00000000;
            r_d.pslverr = !hit;
        end else if (!psel) begin
            r_d.pslverr = 1'b0;
        end

        if (wr_acc && !r_q.pslverr) begin
            for (int e = 0; e < 2; e++) begin
                base = pfm_pkg::PFM_EL_STRIDE * 12'(e);
                if (paddr == base + pfm_pkg::PFM_OFF_CFG) begin
                    r_d.cfg[e].func   = pfm_pkg::pfm_func_type'(pwdata[1:0]);
                    r_d.cfg[e].relays = pwdata[6:2];
                end
                if (paddr == base + pfm_pkg::PFM_OFF_PICKUP) begin
                    r_d.cfg[e].pickup = pfm_clamp_pf(pwdata[7:0]);
                end
                if (paddr == base + pfm_pkg::PFM_OFF_DROPOUT) begin
                    r_d.cfg[e].dropout = pfm_clamp_pf(pwdata[7:0]);
                end
                if (paddr == base + pfm_pkg::PFM_OFF_DELAY) begin
                    r_d.cfg[e].delay = (pwdata[15:0] > pfm_pkg::PFM_DELAY_MAX ||
                                        pwdata[31:16] != 16'h0000)
                                       ? pfm_pkg::PFM_DELAY_MAX : pwdata[15:0];
                end
            end
            if (paddr == pfm_pkg::PFM_OFF_VNOM) begin
                r_d.vnom = pwdata[15:0];
            end
            if (paddr == pfm_pkg::PFM_OFF_IRQSTAT) begin
                irq_clr = pwdata[3:0];
            end
            if (paddr == pfm_pkg::PFM_OFF_IRQMASK) begin
                r_d.irq_mask = pwdata[3:0];
            end
            if (paddr == pfm_pkg::PFM_OFF_CMD) begin
                latch_clr = pwdata[0];
            end
        end

        // Element state machines.
        // Outputs follow the next state, so they leave the flop with it.
        r_d.relay = 5'h00;
        r_d.alarm = 1'b0;
        for (int e = 0; e < 2; e++) begin
            run  = r_q.pf_valid && r_q.v_ok;
            pick = run && r_q.i_ok && ($signed(r_q.pf) < $signed(r_q.cfg[e].pickup));
            drop = $signed(r_q.pf) > $signed(r_q.cfg[e].dropout);
            // The clear comes first, so a latch set in this cycle wins.
            if (latch_clr) begin
                r_d.el[e].latch = 1'b0;
            end
            // Voltage loss or a disabled function ends timing and operation at once.
            if (r_q.cfg[e].func == pfm_pkg::PFM_FN_DISABLED || !run) begin
                r_d.el[e].state = pfm_pkg::PFM_IDLE;
                r_d.el[e].timer = 16'h0000;
            end else begin
                unique case (r_q.el[e].state)
                    pfm_pkg::PFM_IDLE: begin
                        if (pick) begin
                            r_d.el[e].state = pfm_pkg::PFM_PU_TIME;
                            r_d.el[e].timer = 16'h0000;
                        end
                    end
                    pfm_pkg::PFM_PU_TIME: begin
                        if (!pick) begin
                            r_d.el[e].state = pfm_pkg::PFM_IDLE;
                        end else if (r_q.el[e].timer >= r_q.cfg[e].delay) begin
                            r_d.el[e].state = pfm_pkg::PFM_OPER;
                            irq_set[e]      = 1'b1;
                            if (r_q.cfg[e].func == pfm_pkg::PFM_FN_LATCHED) begin
                                r_d.el[e].latch = 1'b1;
                            end
                        end else if (r_q.tick) begin
                            r_d.el[e].timer = r_q.el[e].timer + 16'h0001;
                        end
                    end
                    pfm_pkg::PFM_OPER: begin
                        if (drop) begin
                            r_d.el[e].state = pfm_pkg::PFM_DO_TIME;
                            r_d.el[e].timer = 16'h0000;
                        end
                    end
                    pfm_pkg::PFM_DO_TIME: begin
                        if (!drop) begin
                            r_d.el[e].state = pfm_pkg::PFM_OPER;
                        end else if (r_q.el[e].timer >= r_q.cfg[e].delay) begin
                            r_d.el[e].state = pfm_pkg::PFM_IDLE;
                            irq_set[e + pfm_pkg::PFM_IRQ_RST_LSB] = 1'b1;
                        end else if (r_q.tick) begin
                            r_d.el[e].timer = r_q.el[e].timer + 16'h0001;
                        end
                    end
                endcase
            end
            if (r_q.cfg[e].func == pfm_pkg::PFM_FN_DISABLED) begin
                r_d.el[e].latch = 1'b0;
            end
            active = (r_d.el[e].state == pfm_pkg::PFM_OPER) ||
                     (r_d.el[e].state == pfm_pkg::PFM_DO_TIME);
            if (r_q.cfg[e].func == pfm_pkg::PFM_FN_LATCHED) begin
                active = active || r_d.el[e].latch;
            end
            if (active) begin
                r_d.relay = r_d.relay | r_q.cfg[e].relays;
                if (r_q.cfg[e].func != pfm_pkg::PFM_FN_CONTROL) begin
                    r_d.alarm = 1'b1;
                end
            end
        end

        // Sticky interrupt status: a new event wins over a clear.
        r_d.irq_stat = (r_q.irq_stat & ~irq_clr) | irq_set;
        r_d.irq      = |(r_d.irq_stat & r_d.irq_mask);
    end

    // All state sits in one register, reset to its constant image.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= RST_VAL;
        end else begin
            r_q <= r_d;
        end
    end

    // Every output comes straight from the state register.
    assign prdata    = r_q.prdata;
    assign pready    = r_q.pready;
    assign pslverr   = r_q.pslverr;
    assign relay_out = r_q.relay;
    assign alarm_out = r_q.alarm;
    assign irq       = r_q.irq;

endmodule : pfm_top

// ==== src/pfm_pkg.sv ====
/*
 * Constants, register map and carrier types for the power factor monitor.
 * Assumes a single 20 MHz clock and an APB master with 32-bit data.
 */
package pfm_pkg;

    typedef enum logic [1:0] {PFM_IDLE, PFM_PU_TIME, PFM_OPER, PFM_DO_TIME} pfm_state_type;
    typedef enum logic [1:0] {PFM_FN_DISABLED, PFM_FN_ALARM, PFM_FN_LATCHED,
                              PFM_FN_CONTROL} pfm_func_type;

    localparam int unsigned PFM_CLK_HZ      = 20000000;
    localparam int unsigned PFM_TICK_S      = 1;
    localparam int unsigned PFM_TICK_CYCLES = PFM_TICK_S * PFM_CLK_HZ;

    localparam logic [11:0] PFM_OFF_CFG     = 12'h000;
    localparam logic [11:0] PFM_OFF_PICKUP  = 12'h004;
    localparam logic [11:0] PFM_OFF_DROPOUT = 12'h008;
    localparam logic [11:0] PFM_OFF_DELAY   = 12'h00c;
    localparam logic [11:0] PFM_EL_STRIDE   = 12'h010;
    localparam logic [11:0] PFM_OFF_VNOM    = 12'h020;
    localparam logic [11:0] PFM_OFF_STATUS  = 12'h024;
    localparam logic [11:0] PFM_OFF_IRQSTAT = 12'h028;
    localparam logic [11:0] PFM_OFF_IRQMASK = 12'h02c;
    localparam logic [11:0] PFM_OFF_CMD     = 12'h030;

    localparam int unsigned PFM_CFG_FN_LSB  = 0;
    localparam int unsigned PFM_CFG_RLY_LSB = 2;
    localparam int unsigned PFM_IRQ_RST_LSB = 2;

    localparam logic [1:0]  PFM_RST_FUNC    = 2'h0;
    localparam logic [4:0]  PFM_RST_RELAYS  = 5'h00;
    localparam logic [7:0]  PFM_RST_PICKUP  = 8'h50;
    localparam logic [7:0]  PFM_RST_DROPOUT = 8'h64;
    localparam logic [15:0] PFM_RST_DELAY   = 16'h0032;
    localparam logic [15:0] PFM_RST_VNOM    = 16'h03e8;

    localparam logic [7:0]  PFM_PF_MAX      = 8'h64;
    localparam logic [7:0]  PFM_PF_MIN      = 8'h9d;
    localparam logic [15:0] PFM_DELAY_MAX   = 16'hea60;
    localparam logic [19:0] PFM_VTH_NUM     = 20'h00003;
    localparam logic [19:0] PFM_VTH_DEN     = 20'h0000a;
    localparam logic [39:0] PFM_PF_SCALE    = 40'h0000000064;
    localparam logic [2:0]  PFM_DIV_TOP     = 3'h6;

    typedef struct packed {
        logic [31:0]      p;
        logic [31:0]      s;
        logic             lead;
        logic [2:0][15:0] v;
        logic [2:0]       i_present;
    } pfm_meas_type;

    typedef struct packed {
        pfm_func_type func;
        logic [4:0]   relays;
        logic [7:0]   pickup;
        logic [7:0]   dropout;
        logic [15:0]  delay;
    } pfm_cfg_type;

    typedef struct packed {
        pfm_state_type state;
        logic [15:0]   timer;
        logic          latch;
    } pfm_elem_type;

    typedef struct packed {
        pfm_cfg_type  [1:0] cfg;
        pfm_elem_type [1:0] el;
        logic [15:0]        vnom;
        logic [3:0]         irq_stat;
        logic [3:0]         irq_mask;
        logic               busy;
        logic [2:0]         step;
        logic [39:0]        rem;
        logic [31:0]        den;
        logic [6:0]         quo;
        logic               div_lead;
        logic               div_v_ok;
        logic               div_i_ok;
        logic [7:0]         pf;
        logic               pf_valid;
        logic               v_ok;
        logic               i_ok;
        logic [24:0]        sec_cnt;
        logic               tick;
        logic [4:0]         relay;
        logic               alarm;
        logic               irq;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } pfm_regs_type;

endpackage : pfm_pkg

// ==== verif/pfm_props.sv ====
/* Port checker for pfm_top: APB handshake, refusals and voltage loss.
   Assumes one pclk domain with asynchronous active-low presetn. */
`timescale 1ns/1ps
module pfm_props (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  meas_valid,
    input wire pfm_pkg::pfm_meas_type meas,
    input wire logic [4:0]            relay_out,
    input wire logic                  alarm_out,
    input wire logic                  irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_vloss; meas_valid && meas.v == '0; endsequence
    sequence s_quiet;
        ((relay_out == 5'h00 || alarm_out) && !$rose(alarm_out) && !$rose(|relay_out)) [*8];
    endsequence

    property p_rdy_wait; s_wait |=> pready; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready long");
    property p_rdy_need; pready |-> psel && penable; endproperty
    a_rdy_need: assert property (p_rdy_need) else $error("pready stray");
    property p_err_rose; $rose(pslverr) |-> pready && psel; endproperty
    a_err_rose: assert property (p_err_rose) else $error("pslverr stray");
    property p_err_data; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_err_data: assert property (p_err_data) else $error("refused read data");
    property p_ok_map; pready && paddr <= 12'h030 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
    a_ok_map: assert property (p_ok_map) else $error("mapped access refused");
    property p_rd_hold; !psel |=> $stable(prdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("prdata moved");
    property p_vloss; s_vloss ##1 !meas_valid [*7] |-> ##2 s_quiet; endproperty
    a_vloss: assert property (p_vloss) else $error("operated without voltage");
endmodule : pfm_props

bind pfm_top pfm_props u_pfm_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .meas_valid, .meas, .relay_out, .alarm_out, .irq);

// ==== verif/pfm_meas_model.sv ====
/* Measurement front end model: sends one set of totals, voltages and
   current flags with a one-cycle valid. Assumes pclk only. */
`timescale 1ns/1ps
module pfm_meas_model (
    input wire logic              pclk,
    output logic                  meas_valid,
    output pfm_pkg::pfm_meas_type meas
);
    initial begin
        meas_valid = 1'b0;
        meas = '0;
    end

    // Data is scrambled outside the valid cycle.
    task automatic send(input logic [31:0] p, s, input logic lead,
                        input logic [15:0] va, vb, input logic [2:0] ip);
        pfm_pkg::pfm_meas_type m;
        m.p = p;
        m.s = s;
        m.lead = lead;
        m.v = {vb, vb, va};
        m.i_present = ip;
        @(posedge pclk);
        meas_valid <= 1'b1;
        meas <= m;
        @(posedge pclk);
        meas_valid <= 1'b0;
        meas <= ~m;
        repeat (11) @(posedge pclk);
    endtask : send
endmodule : pfm_meas_model

// ==== verif/power_factor_monitor_tb_top.sv ====
/* Self-checking bench for pfm_top: registers over APB and element scenarios.
   Assumes the bound checker and a ten-cycle second tick. */
`timescale 1ns/1ps
module power_factor_monitor_tb_top;
    logic                  pclk = 1'b0, presetn = 1'b0;
    logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]           paddr = 12'h000;
    logic [31:0]           pwdata = 32'h0, prdata;
    logic                  pready, pslverr, meas_valid, alarm_out, irq, err;
    logic [4:0]            relay_out;
    pfm_pkg::pfm_meas_type meas;
    int                    num_errors = 0, compares = 0, cyc = 0;

    always #25 pclk = ~pclk;

    pfm_top #(.TICK_CYCLES(10)) u_pfm_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .meas_valid, .meas, .relay_out, .alarm_out, .irq);
    pfm_meas_model u_pfm_meas_model (.pclk, .meas_valid, .meas);

    task automatic close_out;
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            @(posedge pclk);
        end
        chk("pready wait", 32'h1, 32'(n));
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask : wr

    task automatic rchk(input logic [11:0] a, input logic [31:0] m, e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk($sformatf("reg %h", a), e, r & m);
    endtask : rchk

    task automatic out_chk(input logic [4:0] rl, input logic al);
        chk("relay_out", rl, relay_out);
        chk("alarm_out", al, alarm_out);
    endtask : out_chk

    task automatic go(input logic [31:0] p, input logic [15:0] v, input logic [2:0] ip);
        u_pfm_meas_model.send(p, 32'h64, 1'b0, v, (v == 16'h0) ? 16'h0 : 16'h190, ip);
    endtask : go

    task automatic t_reset;
        out_chk(5'h00, 1'b0);
        for (int e = 0; e < 2; e++) begin
            rchk(12'(e * 16), 32'h7f, 32'h0);
            rchk(12'(e * 16 + 4), 32'hff, 32'h50);
            rchk(12'(e * 16 + 8), 32'hff, 32'h64);
            rchk(12'(e * 16 + 12), 32'hffff, 32'h32);
        end
    endtask : t_reset

    task automatic t_map;
        rchk(12'h034, 32'hffffffff, 32'h0);
        chk("pslverr", 32'h1, err);
        wr(12'h004, 32'h7f);
        rchk(12'h004, 32'hff, 32'h64);
        wr(12'h004, 32'h9d);
        rchk(12'h004, 32'hff, 32'h9d);
        wr(12'h00c, 32'h10000);
        rchk(12'h00c, 32'hffff, 32'hea60);
        wr(12'h004, 32'h50);
    endtask : t_map

    task automatic t_pf;
        u_pfm_meas_model.send(32'h50, 32'h64, 1'b0, 16'h190, 16'h190, 3'h1);
        rchk(12'h024, 32'h7fff, 32'h750);
        u_pfm_meas_model.send(32'h1, 32'h2, 1'b1, 16'h190, 16'h190, 3'h1);
        rchk(12'h024, 32'h7ff, 32'h7ce);
        u_pfm_meas_model.send(32'h14d, 32'h3e8, 1'b0, 16'h190, 16'h190, 3'h4);
        rchk(12'h024, 32'h7ff, 32'h721);
    endtask : t_pf

    task automatic t_op;
        wr(12'h000, 32'h15);
        wr(12'h008, 32'h5a);
        wr(12'h00c, 32'h0);
        go(32'h46, 16'h190, 3'h1);
        out_chk(5'h05, 1'b1);
        rchk(12'h028, 32'hf, 32'h1);
        chk("irq", 32'h0, irq);
        wr(12'h02c, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h1, irq);
        wr(12'h028, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h0, irq);
        go(32'h5f, 16'h190, 3'h1);
        out_chk(5'h00, 1'b0);
        rchk(12'h028, 32'hf, 32'h4);
        wr(12'h028, 32'hf);
    endtask : t_op

    task automatic t_ctl;
        wr(12'h000, 32'h17);
        wr(12'h010, 32'h63);
        wr(12'h014, 32'h3c);
        wr(12'h01c, 32'h0);
        go(32'h46, 16'h190, 3'h1);
        out_chk(5'h05, 1'b0);
        go(32'h32, 16'h190, 3'h1);
        out_chk(5'h1d, 1'b0);
        go(32'h32, 16'h0, 3'h1);
        out_chk(5'h00, 1'b0);
        go(32'h32, 16'h190, 3'h0);
        out_chk(5'h00, 1'b0);
        rchk(12'h024, 32'h600, 32'h200);
        go(32'h32, 16'h0c8, 3'h1);
        out_chk(5'h00, 1'b0);
        rchk(12'h024, 32'h600, 32'h400);
    endtask : t_ctl

    task automatic t_tmr;
        int n;
        wr(12'h010, 32'h0);
        wr(12'h00c, 32'h4);
        go(32'h46, 16'h190, 3'h1);
        rchk(12'h024, 32'h1800, 32'h800);
        go(32'h46, 16'h0, 3'h0);
        repeat (40) @(posedge pclk);
        out_chk(5'h00, 1'b0);
        rchk(12'h024, 32'h1800, 32'h0);
        go(32'h46, 16'h190, 3'h1);
        out_chk(5'h00, 1'b0);
        for (n = 0; n < 60 && relay_out !== 5'h05; n++) begin
            @(posedge pclk);
        end
        chk("pickup delay", 32'h1, 32'(n >= 28));
        out_chk(5'h05, 1'b0);
    endtask : t_tmr

    task automatic t_latch;
        go(32'h46, 16'h0, 3'h1);
        wr(12'h000, 32'h16);
        wr(12'h00c, 32'h0);
        go(32'h46, 16'h190, 3'h1);
        out_chk(5'h05, 1'b1);
        go(32'h5f, 16'h190, 3'h1);
        out_chk(5'h05, 1'b1);
        rchk(12'h024, 32'h9800, 32'h8000);
        wr(12'h030, 32'h1);
        repeat (2) @(posedge pclk);
        out_chk(5'h00, 1'b0);
    endtask : t_latch

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_map();
        t_pf();
        t_op();
        t_ctl();
        t_tmr();
        t_latch();
        close_out();
    end
endmodule : power_factor_monitor_tb_top
